// ===== aln_engine.sv
// async transfer list engine: nak retry, completion map, port enable
// assumes responses come from a same-clock sequencer, port pins are async
//
// Contract
// - reload zero means endless nak retry
// - countdown reaching zero raises interrupt, descriptor stops
// - reload zero nak raises no interrupt
// - nak without retry sets async list interrupt
// - completion map read clears returned bits
// - descriptor read shows its valid bit
// - port error clears enable, connect stays
// - port reset command disconnects the device
// - enable loss leaves other ports untouched
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module aln_engine
(
  input wire logic core_clk, // core clock, 250 MHz
  input wire logic rst_n, // sync reset, active low
  input wire logic [11:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic resp_valid, // token response present
  output logic resp_ready, // engine can take a response
  input wire logic [2:0] resp_slot, // descriptor slot of response
  input wire logic [1:0] resp_code, // response kind
  output logic token_req, // issue in token, one-cycle pulse
  output logic [2:0] token_slot, // slot of token to issue
  input wire logic sof_tick, // frame start pulse
  input wire logic [2:0] port_connect_pin, // device present per port
  input wire logic [2:0] port_error_pin, // port error per port
  output logic [2:0] port_enable, // port enabled
  output logic [2:0] port_disconnect, // port held in reset
  output logic irq // level interrupt
);

  typedef struct packed
  {
    aln_pkg::aln_eng_t st;
    logic [2:0] op_slot;
    aln_pkg::aln_resp_t op_code;
    logic [7:0] valid;
    logic [7:0] done;
    logic [7:0] pend;
    logic tok_vld;
    logic [2:0] tok_slot;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [31:0] rdata;
    logic rd_desc;
    logic [2:0] conn_s1;
    logic [2:0] conn_s2;
    logic [2:0] err_s1;
    logic [2:0] err_s2;
    logic [2:0] en;
    logic [2:0][11:0] rst_cnt;
  } aln_st_t;

  aln_st_t s_reg;
  aln_st_t s_next;

  logic sw_desc_we;
  logic [9:0] mem_wdata;
  logic mem_we;
  logic [2:0] mem_wslot;
  logic [9:0] sw_data;
  logic [9:0] eng_data;
  logic [3:0] rl;
  logic [3:0] cd;
  logic [1:0] cerr;
  logic ap_go;
  logic ap_nak;
  logic ap_last;
  logic [7:0] done_set;
  logic [2:0] port_rst_wr;
  logic rd_valid_sel;
  logic desc_hit;

  // ----------------------------------------------------------------
  // descriptor store
  // ----------------------------------------------------------------
  aln_desc_mem u_mem
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_slot(mem_wslot),
    .wr_data(mem_wdata),
    .sw_slot(reg_addr[4:2]),
    .sw_data(sw_data),
    .eng_rd(s_reg.st == aln_pkg::ENG_FETCH),
    .eng_slot(s_reg.op_slot),
    .eng_data(eng_data)
  );

  assign desc_hit = reg_addr[11:5] == aln_pkg::OFS_DESC_BASE[11:5];
  assign sw_desc_we = reg_wr && desc_hit;
  assign rl = eng_data[aln_pkg::DESC_RL_LSB +: aln_pkg::FLD_W];
  assign cd = eng_data[aln_pkg::DESC_CD_LSB +: aln_pkg::FLD_W];
  assign cerr = eng_data[aln_pkg::DESC_CERR_LSB +: aln_pkg::CERR_W];
  assign ap_go = s_reg.st == aln_pkg::ENG_APPLY && s_reg.valid[s_reg.op_slot] && !sw_desc_we;
  assign ap_nak = ap_go && s_reg.op_code == aln_pkg::RESP_NAK;
  assign ap_last = cd <= 4'h1;
  assign rd_valid_sel = s_reg.valid[reg_addr[4:2]];
  assign port_rst_wr = (reg_wr && reg_addr == aln_pkg::OFS_PORT) ?
    reg_wdata[aln_pkg::PORT_RST_LSB +: aln_pkg::NPORT] : 3'h0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    mem_we = 1'b0;
    mem_wslot = s_reg.op_slot;
    mem_wdata = eng_data;
    done_set = 8'h00;

    // token issue: lowest pending slot first
    s_next.tok_vld = |s_reg.pend;
    s_next.tok_slot = 3'h0;
    for (int i = aln_pkg::NSLOT - 1; i >= 0; i--)
    begin
      if (s_reg.pend[i])
      begin
        s_next.tok_slot = 3'(i);
      end
    end
    if (s_next.tok_vld)
    begin
      s_next.pend[s_next.tok_slot] = 1'b0;
    end

    // engine sequence
    unique case (s_reg.st)
      aln_pkg::ENG_IDLE:
      begin
        if (resp_valid)
        begin
          s_next.op_slot = resp_slot;
          s_next.op_code = aln_pkg::aln_resp_t'(resp_code);
          s_next.st = aln_pkg::ENG_FETCH;
        end
      end
      aln_pkg::ENG_FETCH:
      begin
        if (sw_desc_we && reg_addr[4:2] == s_reg.op_slot)
        begin
          s_next.st = aln_pkg::ENG_IDLE;
        end
        else
        begin
          s_next.st = aln_pkg::ENG_APPLY;
        end
      end
      aln_pkg::ENG_APPLY:
      begin
        if (!sw_desc_we || reg_addr[4:2] == s_reg.op_slot)
        begin
          s_next.st = aln_pkg::ENG_IDLE;
        end
        if (ap_go)
        begin
          unique case (s_reg.op_code)
            aln_pkg::RESP_NAK:
            begin
              if (rl == 4'h0)
              begin
                s_next.pend[s_reg.op_slot] = 1'b1;
              end
              else if (!ap_last)
              begin
                mem_we = 1'b1;
                mem_wdata[aln_pkg::DESC_CD_LSB +: aln_pkg::FLD_W] = cd - 4'h1;
                s_next.pend[s_reg.op_slot] = 1'b1;
              end
              else
              begin
                mem_we = 1'b1;
                mem_wdata[aln_pkg::DESC_CD_LSB +: aln_pkg::FLD_W] = 4'h0;
                s_next.valid[s_reg.op_slot] = 1'b0;
                s_next.stat[aln_pkg::IRQ_ASYNC_BIT] = 1'b1;
              end
            end
            aln_pkg::RESP_ACK, aln_pkg::RESP_DATA:
            begin
              mem_we = 1'b1;
              mem_wdata[aln_pkg::DESC_CD_LSB +: aln_pkg::FLD_W] = rl;
              s_next.valid[s_reg.op_slot] = 1'b0;
              done_set[s_reg.op_slot] = 1'b1;
              s_next.stat[aln_pkg::IRQ_ASYNC_BIT] = 1'b1;
            end
            aln_pkg::RESP_ERR:
            begin
              mem_we = 1'b1;
              if (cerr > 2'h1)
              begin
                mem_wdata[aln_pkg::DESC_CERR_LSB +: aln_pkg::CERR_W] = cerr - 2'h1;
                s_next.pend[s_reg.op_slot] = 1'b1;
              end
              else
              begin
                mem_wdata[aln_pkg::DESC_CERR_LSB +: aln_pkg::CERR_W] = 2'h0;
                s_next.valid[s_reg.op_slot] = 1'b0;
                done_set[s_reg.op_slot] = 1'b1;
                s_next.stat[aln_pkg::IRQ_ASYNC_BIT] = 1'b1;
              end
            end
          endcase
        end
      end
    endcase

    // software descriptor write wins the store
    if (sw_desc_we)
    begin
      mem_we = 1'b1;
      mem_wslot = reg_addr[4:2];
      mem_wdata = reg_wdata[aln_pkg::DESC_W-1:0];
      s_next.valid[reg_addr[4:2]] = reg_wdata[aln_pkg::DESC_VALID_BIT];
      if (reg_wdata[aln_pkg::DESC_VALID_BIT])
      begin
        s_next.pend[reg_addr[4:2]] = 1'b1;
      end
    end

    // register writes and clear on read; async set wins unless that bit was already set, frame and port sets always win
    if (reg_wr && reg_addr == aln_pkg::OFS_IRQ_STAT)
    begin
      s_next.stat = s_next.stat & ~(reg_wdata[aln_pkg::IRQ_W-1:0] & ~(s_next.stat ^ s_reg.stat));
    end
    if (reg_wr && reg_addr == aln_pkg::OFS_IRQ_MASK)
    begin
      s_next.mask = reg_wdata[aln_pkg::IRQ_W-1:0];
    end
    if (reg_rd && reg_addr == aln_pkg::OFS_DONE_MAP)
    begin
      s_next.done = 8'h00;
    end
    s_next.done = s_next.done | done_set;
    if (sof_tick)
    begin
      s_next.stat[aln_pkg::IRQ_SOF_BIT] = 1'b1;
    end

    // ports, each on its own state
    s_next.conn_s1 = port_connect_pin;
    s_next.conn_s2 = s_reg.conn_s1;
    s_next.err_s1 = port_error_pin;
    s_next.err_s2 = s_reg.err_s1;
    for (int p = 0; p < aln_pkg::NPORT; p++)
    begin
      if (s_reg.rst_cnt[p] != 12'h000)
      begin
        s_next.rst_cnt[p] = s_reg.rst_cnt[p] - 12'h001;
        s_next.en[p] = (s_reg.rst_cnt[p] == 12'h001) && s_reg.conn_s2[p];
      end
      else if (port_rst_wr[p])
      begin
        s_next.rst_cnt[p] = aln_pkg::PORT_RESET_CYC;
        s_next.en[p] = 1'b0;
      end
      else if (s_reg.err_s2[p] || !s_reg.conn_s2[p])
      begin
        s_next.en[p] = 1'b0;
      end
      if (s_reg.en[p] && !s_next.en[p])
      begin
        s_next.stat[aln_pkg::IRQ_PORT_BIT] = 1'b1;
      end
    end

    // read data, one cycle after the strobe
    s_next.rdata = 32'h0000_0000;
    s_next.rd_desc = 1'b0;
    if (reg_rd)
    begin
      if (desc_hit)
      begin
        s_next.rd_desc = 1'b1;
        s_next.rdata[aln_pkg::DESC_VALID_BIT] = rd_valid_sel;
      end
      else
      begin
        unique case (reg_addr)
          aln_pkg::OFS_DONE_MAP: s_next.rdata[7:0] = s_reg.done;
          aln_pkg::OFS_VALID_MAP: s_next.rdata[7:0] = s_reg.valid;
          aln_pkg::OFS_IRQ_STAT: s_next.rdata[2:0] = s_reg.stat;
          aln_pkg::OFS_IRQ_MASK: s_next.rdata[2:0] = s_reg.mask;
          aln_pkg::OFS_PORT:
          begin
            s_next.rdata[aln_pkg::PORT_EN_LSB +: aln_pkg::NPORT] = s_reg.en;
            s_next.rdata[aln_pkg::PORT_CONN_LSB +: aln_pkg::NPORT] = s_reg.conn_s2;
            for (int p = 0; p < aln_pkg::NPORT; p++)
            begin
              s_next.rdata[aln_pkg::PORT_RST_LSB + p] = s_reg.rst_cnt[p] != 12'h000;
            end
          end
          default: s_next.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.mask <= aln_pkg::IRQ_MASK_RST;
      s_reg.done <= aln_pkg::MAP_RST;
      s_reg.valid <= aln_pkg::MAP_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign resp_ready = s_reg.st == aln_pkg::ENG_IDLE;
  assign token_req = s_reg.tok_vld;
  assign token_slot = s_reg.tok_slot;
  assign port_enable = s_reg.en;
  assign irq = |(s_reg.stat & s_reg.mask);
  assign reg_rdata = s_reg.rd_desc ?
    (s_reg.rdata | {22'h00_0000, sw_data}) : s_reg.rdata;
  for (genvar g = 0; g < aln_pkg::NPORT; g++)
  begin : g_disc
    assign port_disconnect[g] = s_reg.rst_cnt[g] != 12'h000;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_nak_endless: assert property (@(posedge core_clk) disable iff (!rst_n)
    ap_nak && rl == 4'h0 |=> s_reg.pend[$past(s_reg.op_slot)] && s_reg.valid[$past(s_reg.op_slot)])
    else $error("nak with zero reload not retried");

  chk_count_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    ap_nak && rl != 4'h0 && ap_last |=> !s_reg.valid[$past(s_reg.op_slot)] ##1 irq || !s_reg.mask[0])
    else $error("countdown end did not stop descriptor");

  chk_hw_noirq: assert property (@(posedge core_clk) disable iff (!rst_n)
    ap_nak && rl == 4'h0 && !s_reg.stat[0] |=> !s_reg.stat[0])
    else $error("zero reload nak raised interrupt");

  chk_nak_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
    ap_nak && rl != 4'h0 && ap_last |=> s_reg.stat[0])
    else $error("unretried nak left status clear");

  chk_done_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == aln_pkg::OFS_DONE_MAP |=>
    (reg_rdata[7:0] & s_reg.done & ~$past(done_set)) == 8'h00)
    else $error("read completion bit survived");

  chk_desc_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && desc_hit |=> reg_rdata[31] == $past(rd_valid_sel))
    else $error("descriptor read shows wrong valid");

  chk_count_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    ap_nak && rl != 4'h0 && !ap_last |-> mem_we &&
    mem_wdata[aln_pkg::DESC_CD_LSB +: aln_pkg::FLD_W] == cd - 4'h1 ##1 token_req || s_reg.pend != 8'h00)
    else $error("countdown not decremented by one");

  for (genvar g = 0; g < aln_pkg::NPORT; g++)
  begin : g_chk
    chk_err_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_reg.err_s2[g] && s_reg.rst_cnt[g] == 12'h000 |=> !s_reg.en[g])
      else $error("port error kept enable");

    chk_reset_disc: assert property (@(posedge core_clk) disable iff (!rst_n)
      port_rst_wr[g] && s_reg.rst_cnt[g] == 12'h000 |=> port_disconnect[g] [*8] ##0 !port_enable[g])
      else $error("port reset did not disconnect");

    chk_port_alone: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_reg.en[g] && !s_reg.err_s2[g] && s_reg.conn_s2[g] && !port_rst_wr[g] &&
      s_reg.rst_cnt[g] == 12'h000 |=> s_reg.en[g])
      else $error("port enable lost without own cause");
  end

endmodule // aln_engine

// ===== aln_pkg.sv
// constants, offsets and types of the async list engine
// assumes a 250 MHz core clock and a byte-addressed plain register port
package aln_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NSLOT = 8;
  localparam int SLOT_W = 3;
  localparam int NPORT = 3;
  localparam int ADDR_W = 12;
  localparam int DESC_W = 10;
  localparam int FLD_W = 4;
  localparam int CERR_W = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_DONE_MAP = 12'h300;
  localparam logic [11:0] OFS_VALID_MAP = 12'h304;
  localparam logic [11:0] OFS_PORT = 12'h308;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h310;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h314;
  localparam logic [11:0] OFS_DESC_BASE = 12'h400;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DESC_RL_LSB = 0;
  localparam int DESC_CD_LSB = 4;
  localparam int DESC_CERR_LSB = 8;
  localparam int DESC_VALID_BIT = 31;
  localparam int IRQ_ASYNC_BIT = 0;
  localparam int IRQ_SOF_BIT = 1;
  localparam int IRQ_PORT_BIT = 2;
  localparam int PORT_EN_LSB = 0;
  localparam int PORT_CONN_LSB = 4;
  localparam int PORT_RST_LSB = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [7:0] MAP_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int PORT_RESET_NS = 10000;
  localparam logic [11:0] PORT_RESET_CYC = 12'((PORT_RESET_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    RESP_NAK = 2'b00,
    RESP_ACK = 2'b01,
    RESP_DATA = 2'b10,
    RESP_ERR = 2'b11
  } aln_resp_t;

  typedef enum logic [1:0]
  {
    ENG_IDLE = 2'b00,
    ENG_FETCH = 2'b01,
    ENG_APPLY = 2'b10
  } aln_eng_t;

endpackage

// ===== aln_desc_mem.sv
// descriptor store: one write port, two registered read ports
// assumes the caller never needs write-through; reads return old data
`timescale 1ns/1ps
module aln_desc_mem
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // sync reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [2:0] wr_slot, // write slot
  input wire logic [9:0] wr_data, // write data
  input wire logic [2:0] sw_slot, // software read slot
  output logic [9:0] sw_data, // software read data, registered
  input wire logic eng_rd, // engine read strobe
  input wire logic [2:0] eng_slot, // engine read slot
  output logic [9:0] eng_data // engine read data, held until next read
);

  typedef struct packed
  {
    logic [aln_pkg::NSLOT-1:0][aln_pkg::DESC_W-1:0] cells;
    logic [aln_pkg::DESC_W-1:0] sw_q;
    logic [aln_pkg::DESC_W-1:0] eng_q;
  } aln_mem_st_t;

  aln_mem_st_t m_reg;
  aln_mem_st_t m_next;

  always_comb
  begin
    m_next = m_reg;
    m_next.sw_q = m_reg.cells[sw_slot];
    if (eng_rd)
    begin
      m_next.eng_q = m_reg.cells[eng_slot];
    end
    if (wr_en)
    begin
      m_next.cells[wr_slot] = wr_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      m_reg <= '0;
    end
    else
    begin
      m_reg <= m_next;
    end
  end

  assign sw_data = m_reg.sw_q;
  assign eng_data = m_reg.eng_q;

endmodule // aln_desc_mem

// ===== aln_dev_model.sv
// downstream device model: answers each in token with one response
// assumes tokens are one-cycle pulses and responses wait for resp_ready
`timescale 1ns/1ps
module aln_dev_model
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // sync reset, active low
  input wire logic token_req, // token pulse from engine
  input wire logic [2:0] token_slot, // slot of token
  input wire logic resp_ready, // engine takes response
  input wire logic [15:0] resp_codes, // response kind per slot
  output logic resp_valid, // response present
  output logic [2:0] resp_slot, // slot of response
  output logic [1:0] resp_code // response kind
);
  // ----------------------------------------------------------------
  // token queue and delayed answer
  // ----------------------------------------------------------------
  logic [2:0] slot_q[$];
  logic [2:0] cur;
  logic busy;
  int wait_cnt;

  initial
  begin
    resp_valid = 1'b0;
    resp_slot = 3'h0;
    resp_code = 2'h0;
    busy = 1'b0;
    wait_cnt = 0;
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      slot_q.delete();
      resp_valid <= 1'b0;
      busy = 1'b0;
    end
    else
    begin
      if (token_req === 1'b1)
        slot_q.push_back(token_slot);
      if (resp_valid && resp_ready)
      begin
        // released lines show no stale value
        resp_valid <= 1'b0;
        resp_slot <= ~resp_slot;
        resp_code <= ~resp_code;
        busy = 1'b0;
      end
      else if (!busy && slot_q.size() > 0)
      begin
        cur = slot_q.pop_front();
        busy = 1'b1;
        wait_cnt = 2;
      end
      else if (busy && !resp_valid)
      begin
        if (wait_cnt == 0)
        begin
          resp_valid <= 1'b1;
          resp_slot <= cur;
          resp_code <= resp_codes[2*cur+:2];
        end
        else
          wait_cnt--;
      end
    end
  end
endmodule // aln_dev_model

// ===== aln_tb.sv
// self-checking bench of the async list engine over its register port
// assumes the device model answers tokens; port pins driven by the bench
`timescale 1ns/1ps
module tb;
  logic core_clk, rst_n, reg_wr, reg_rd, resp_valid, resp_ready, token_req, sof_tick, irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [2:0] resp_slot, token_slot, port_connect_pin, port_error_pin, port_enable, port_disconnect;
  logic [1:0] resp_code;
  logic [15:0] resp_codes;
  int fails, compares, base, n;
  int tok_cnt[8];

  aln_engine dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .resp_valid(resp_valid), .resp_ready(resp_ready), .resp_slot(resp_slot),
    .resp_code(resp_code), .token_req(token_req), .token_slot(token_slot),
    .sof_tick(sof_tick), .port_connect_pin(port_connect_pin),
    .port_error_pin(port_error_pin), .port_enable(port_enable),
    .port_disconnect(port_disconnect), .irq(irq));
  aln_dev_model dev_u (.core_clk(core_clk), .rst_n(rst_n), .token_req(token_req),
    .token_slot(token_slot), .resp_ready(resp_ready), .resp_codes(resp_codes),
    .resp_valid(resp_valid), .resp_slot(resp_slot), .resp_code(resp_code));

  // ----------------------------------------------------------------
  // clock, token counter, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (rst_n === 1'b1 && token_req === 1'b1)
      tok_cnt[token_slot] <= tok_cnt[token_slot] + 1;

  initial
  begin
    #80000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    rd_reg(a, rd);
    chk(rd, exp, msg);
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      step();
      n++;
    end
  endtask

  function automatic logic [11:0] desc_a(input int s);
    return aln_pkg::OFS_DESC_BASE + 12'(4 * s);
  endfunction

  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    sof_tick = 1'b0;
    port_connect_pin = 3'h7;
    port_error_pin = 3'h0;
    resp_codes = 16'h0000;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(aln_pkg::OFS_IRQ_STAT, 32'h0, "status reset");
    rd_chk(aln_pkg::OFS_IRQ_MASK, 32'h0, "mask reset");
    rd_chk(aln_pkg::OFS_DONE_MAP, 32'h0, "done map reset");
    rd_chk(aln_pkg::OFS_VALID_MAP, 32'h0, "valid map reset");
    rd_chk(12'h0f0, 32'h0, "unmapped read");
    $display("test reset done");

    // software retry: reload and countdown all ones, every answer nak
    wr_reg(aln_pkg::OFS_IRQ_MASK, 32'h1);
    base = tok_cnt[0];
    wr_reg(desc_a(0), 32'h8000_00ff);
    wait_irq();
    chk({31'h0, irq}, 32'h1, "irq at countdown zero");
    chk(32'(tok_cnt[0] - base), 32'd15, "token count");
    rd_chk(desc_a(0), 32'h0000_000f, "descriptor after naks");
    rd_chk(aln_pkg::OFS_IRQ_STAT, 32'h1, "async status");
    wr_reg(aln_pkg::OFS_IRQ_STAT, 32'h1);
    rd_chk(aln_pkg::OFS_IRQ_STAT, 32'h0, "async cleared");
    chk({31'h0, irq}, 32'h0, "irq low after clear");
    $display("test software retry done");

    // hardware retry: zero reload, error count two, naks then data
    base = tok_cnt[1];
    wr_reg(desc_a(1), 32'h8000_0200);
    n = 0;
    while (tok_cnt[1] - base < 20 && n < 4000)
    begin
      step();
      n++;
    end
    chk(32'(tok_cnt[1] - base >= 20), 32'h1, "endless retry");
    rd_chk(aln_pkg::OFS_IRQ_STAT, 32'h0, "no nak status");
    chk({31'h0, irq}, 32'h0, "no nak irq");
    rd_chk(aln_pkg::OFS_VALID_MAP, 32'h2, "valid while retrying");
    @(posedge core_clk);
    resp_codes[3:2] <= aln_pkg::RESP_DATA;
    wait_irq();
    chk({31'h0, irq}, 32'h1, "irq on data");
    rd_chk(aln_pkg::OFS_DONE_MAP, 32'h2, "done bit");
    rd_chk(aln_pkg::OFS_DONE_MAP, 32'h0, "done cleared by read");
    rd_chk(aln_pkg::OFS_VALID_MAP, 32'h0, "valid map cleared");
    rd_chk(desc_a(1), 32'h0000_0200, "descriptor valid low");
    $display("test hardware retry done");

    // mask and frame tick polling
    wr_reg(aln_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (2) step();
    chk({31'h0, irq}, 32'h0, "masked irq");
    @(posedge core_clk);
    sof_tick <= 1'b1;
    @(posedge core_clk);
    sof_tick <= 1'b0;
    rd_chk(aln_pkg::OFS_IRQ_STAT, 32'h3, "frame tick status");
    wr_reg(aln_pkg::OFS_IRQ_MASK, 32'h2);
    repeat (2) step();
    chk({31'h0, irq}, 32'h1, "frame irq unmasked");
    wr_reg(aln_pkg::OFS_IRQ_STAT, 32'h3);
    repeat (2) step();
    chk({31'h0, irq}, 32'h0, "irq after w1c");
    rd_chk(aln_pkg::OFS_IRQ_STAT, 32'h0, "status after w1c");
    $display("test interrupt done");

    // error count runs out, then an ack reloads the countdown
    @(posedge core_clk);
    resp_codes[5:4] <= aln_pkg::RESP_ERR;
    base = tok_cnt[2];
    wr_reg(desc_a(2), 32'h8000_0200);
    repeat (60) step();
    chk(32'(tok_cnt[2] - base), 32'd2, "error count retries");
    rd_chk(aln_pkg::OFS_DONE_MAP, 32'h4, "done after errors");
    rd_chk(desc_a(2), 32'h0000_0000, "error count spent");
    @(posedge core_clk);
    resp_codes[5:4] <= aln_pkg::RESP_ACK;
    wr_reg(desc_a(2), 32'h8000_0035);
    repeat (30) step();
    rd_chk(aln_pkg::OFS_DONE_MAP, 32'h4, "done on ack");
    rd_chk(desc_a(2), 32'h0000_0055, "countdown reloaded on ack");
    wr_reg(aln_pkg::OFS_IRQ_STAT, 32'h1);
    rd_chk(aln_pkg::OFS_IRQ_STAT, 32'h0, "status after ack clear");
    $display("test error count done");

    // ports: reset all three, then an error on the middle one
    rd_chk(aln_pkg::OFS_PORT, 32'h070, "ports start disabled");
    wr_reg(aln_pkg::OFS_PORT, 32'h700);
    step();
    chk({29'h0, port_disconnect}, 32'h7, "port reset drives disconnect");
    rd_chk(aln_pkg::OFS_PORT, 32'h770, "reset busy");
    n = 0;
    while (port_disconnect !== 3'h0 && n < 3000)
    begin
      step();
      n++;
    end
    chk(32'(n > 2400 && n < 2600), 32'h1, "port reset length");
    repeat (4) step();
    rd_chk(aln_pkg::OFS_PORT, 32'h077, "ports enabled");
    @(posedge core_clk);
    port_error_pin <= 3'h2;
    repeat (6) step();
    rd_chk(aln_pkg::OFS_PORT, 32'h075, "error clears one enable");
    chk({29'h0, port_enable}, 32'h5, "enable pins");
    rd_chk(aln_pkg::OFS_IRQ_STAT, 32'h4, "enable fell status");
    chk({31'h0, irq}, 32'h0, "port status masked");
    $display("test ports done");
    tally_and_finish();
  end
endmodule // tb
